// >>> rtl/pump_sleep_cfg.svh
`ifndef PUMP_SLEEP_CFG_SVH
`define PUMP_SLEEP_CFG_SVH
// Register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_SLEEP_LEVEL 8'h04
`define OFS_SLEEP_SPEED 8'h08
`define OFS_SLEEP_POWER 8'h0c
`define OFS_PRESS_LEVEL 8'h10
`define OFS_WAKE_LEVEL 8'h14
`define OFS_WAKE_ERROR 8'h18
`define OFS_SLEEP_DELAY 8'h1c
`define OFS_WAKE_DELAY 8'h20
`define OFS_BOOST_SPEED 8'h24
`define OFS_BOOST_TIME 8'h28
`define OFS_SCALE 8'h2c
`define OFS_STATUS 8'h30
// Control register field positions.
`define CTRL_EN_BIT 0
`define CTRL_SMODE_LSB 1
`define CTRL_WMODE_LSB 4
`define CTRL_INV_BIT 6
`define CTRL_SWSRC_LSB 7
`define CTRL_SWIDX_LSB 9
`define CTRL_SNSRC_LSB 12
`define CTRL_ORMASK_LSB 14
// Reset values.
`define RST_CTRL 32'h0000_0000
`define RST_LEVEL 16'h0000
`define RST_SCALE 32'hffff_0000
// Timing: the control tick period and the bus clock period.
`define PCLK_NS 4
`define CTL_TICK_NS 1000
`define CTL_TICK_CYC ((`CTL_TICK_NS + `PCLK_NS - 1) / `PCLK_NS)
`endif

// >>> rtl/pump_sleep_pkg.sv
package pump_sleep_pkg;
  typedef enum logic [2:0] {
    SM_NONE = 3'h0, SM_SWITCH = 3'h1, SM_FLOW = 3'h2, SM_SPEED = 3'h3,
    SM_POWER = 3'h4, SM_PRESSURE = 3'h5, SM_ANY = 3'h6
  } sleep_mode_t;
  typedef enum logic [1:0] {
    WM_FEEDBACK = 2'h0, WM_ERROR = 2'h1, WM_PRESSURE = 2'h2
  } wake_mode_t;
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0, SRC_ANALOG = 2'h1, SRC_VIRTUAL = 2'h2, SRC_PULSE = 2'h3
  } sensor_src_t;
  typedef enum logic [3:0] {
    ST_RUNNING = 4'b0001, ST_BOOST = 4'b0010, ST_SLEEPING = 4'b0100, ST_WAKING = 4'b1000
  } sup_state_t;
  // Process measurements, all unsigned in process units except raw sensors.
  typedef struct packed {
    logic [15:0] feedback;
    logic [15:0] reference;
    logic [15:0] pressure;
    logic [15:0] out_freq;
    logic [15:0] out_power;
    logic [15:0] sens_analog;
    logic [15:0] sens_virtual;
    logic [15:0] sens_pulse;
  } process_in_t;
  // Regulation context from the command path.
  typedef struct packed {
    logic fb_configured;
    logic reg_configured;
    logic chan1_selected;
    logic auto_mode;
    logic run_order;
    logic aux_pumps_off;
  } drive_ctx_t;
endpackage

// >>> rtl/pump_sleep_wakeup_control.sv
`timescale 1ns/10ps
`include "pump_sleep_cfg.svh"
// Notes on behaviour
// - Supervisor acts only when a feedback source is configured.
// - Closed loop active needs regulation configured, channel 1, automatic mode.
// - Without wake condition, sleep after sleep condition outlasts the sleep delay.
// - Flow mode: sleep while sensor value below sleep level.
// - Switch mode: sleep while assigned switch input is active.
// - Speed mode: sleep when frequency below sleep speed and auxiliary pumps off.
// - Power mode: sleep while output power below sleep power and auxiliary pumps off.
// - Pressure mode: sleep while pressure above its sleep level.
// - Multiple mode: OR of the enabled conditions.
// - Wake only after wake condition outlasts the wake delay.
// - Feedback wake, direct: feedback below wake level.
// - Feedback wake, inverted: feedback above wake level.
// - Error wake, direct: feedback below reference minus wake error.
// - Error wake, inverted: feedback above reference plus wake error.
// - Pressure wake: pressure below wake level.
// - Entering sleep: boost speed for boost time, then stop.
// - Boost time zero skips the boost phase.
// - Run order in auto with wake condition starts regulation at once.
// - Run order in auto without wake condition sleeps directly, no boost.
// - Switch to auto while running keeps running, no sleep.
// - Switch source is none, a digital input or a control-word bit.
// - Sensor source none, analog, virtual or pulse, scaled by low/high limits.
// - Sleep mode resets to not configured, so no sleep entry.
module pump_sleep_wakeup_control #(
  parameter int DW = 16,
  parameter int NSW = 8,
  parameter int TICK_CYC = `CTL_TICK_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Process side
  input wire pump_sleep_pkg::process_in_t proc_in,
  input wire pump_sleep_pkg::drive_ctx_t ctx_in,
  input wire logic [NSW-1:0] switch_pins,
  input wire logic [NSW-1:0] ctrl_word_bits,
  // Motor speed path
  output logic regulator_run,
  output logic motor_halt,
  output logic boost_active,
  output logic [15:0] boost_speed_ref,
  output logic sleeping
);
  // ********************************
  // Elaboration checks
  // ********************************
  if (DW != 16) begin : g_bad_dw
    $error("Only a data width of 16 is supported.");
  end
  if (NSW < 1 || NSW > 8) begin : g_bad_nsw
    $error("Between one and eight switch inputs are supported.");
  end
  if (TICK_CYC < 1 || TICK_CYC > 4096) begin : g_bad_tick
    $error("Tick divider must lie between 1 and 4096.");
  end

  // ********************************
  // Functions
  // ********************************
  // Maps a 16-bit raw value onto the lo..hi process range.
  function automatic logic [15:0] scale(input logic [15:0] raw, input logic [15:0] lo,
                                        input logic [15:0] hi);
    logic [31:0] prod;
    prod = 32'(raw) * 32'(hi - lo);
    return 16'(lo + prod[31:16]);
  endfunction

  // ********************************
  // Registers
  // ********************************
  logic [31:0] ctrl_q;
  logic [15:0] sleep_level_q, sleep_speed_q, sleep_power_q, press_level_q;
  logic [15:0] wake_level_q, wake_error_q, sleep_delay_q, wake_delay_q;
  logic [15:0] boost_speed_q, boost_time_q;
  logic [31:0] scale_q;
  pump_sleep_pkg::sup_state_t state_q;
  logic sleep_cond, wake_cond, sup_active;
  logic [15:0] wr16;
  logic wr_en, addr_ok;

  assign wr_en = psel & penable & pwrite;
  assign wr16 = pwdata[15:0];
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      `OFS_CTRL, `OFS_SLEEP_LEVEL, `OFS_SLEEP_SPEED, `OFS_SLEEP_POWER, `OFS_PRESS_LEVEL,
      `OFS_WAKE_LEVEL, `OFS_WAKE_ERROR, `OFS_SLEEP_DELAY, `OFS_WAKE_DELAY,
      `OFS_BOOST_SPEED, `OFS_BOOST_TIME, `OFS_SCALE, `OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  // Status is read-only; writing it is refused like an unmapped address.
  assign pslverr = psel & penable & (~addr_ok | (pwrite & paddr == `OFS_STATUS));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RST_CTRL;
      sleep_level_q <= `RST_LEVEL;
      sleep_speed_q <= `RST_LEVEL;
      sleep_power_q <= `RST_LEVEL;
      press_level_q <= `RST_LEVEL;
      wake_level_q <= `RST_LEVEL;
      wake_error_q <= `RST_LEVEL;
      sleep_delay_q <= `RST_LEVEL;
      wake_delay_q <= `RST_LEVEL;
      boost_speed_q <= `RST_LEVEL;
      boost_time_q <= `RST_LEVEL;
      scale_q <= `RST_SCALE;
    end else if (wr_en) begin
      case (paddr)
        `OFS_CTRL: ctrl_q <= pwdata;
        `OFS_SLEEP_LEVEL: sleep_level_q <= wr16;
        `OFS_SLEEP_SPEED: sleep_speed_q <= wr16;
        `OFS_SLEEP_POWER: sleep_power_q <= wr16;
        `OFS_PRESS_LEVEL: press_level_q <= wr16;
        `OFS_WAKE_LEVEL: wake_level_q <= wr16;
        `OFS_WAKE_ERROR: wake_error_q <= wr16;
        `OFS_SLEEP_DELAY: sleep_delay_q <= wr16;
        `OFS_WAKE_DELAY: wake_delay_q <= wr16;
        `OFS_BOOST_SPEED: boost_speed_q <= wr16;
        `OFS_BOOST_TIME: boost_time_q <= wr16;
        `OFS_SCALE: scale_q <= pwdata;
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup phase so it comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      case (paddr)
        `OFS_CTRL: prdata <= ctrl_q;
        `OFS_SLEEP_LEVEL: prdata <= {16'h0000, sleep_level_q};
        `OFS_SLEEP_SPEED: prdata <= {16'h0000, sleep_speed_q};
        `OFS_SLEEP_POWER: prdata <= {16'h0000, sleep_power_q};
        `OFS_PRESS_LEVEL: prdata <= {16'h0000, press_level_q};
        `OFS_WAKE_LEVEL: prdata <= {16'h0000, wake_level_q};
        `OFS_WAKE_ERROR: prdata <= {16'h0000, wake_error_q};
        `OFS_SLEEP_DELAY: prdata <= {16'h0000, sleep_delay_q};
        `OFS_WAKE_DELAY: prdata <= {16'h0000, wake_delay_q};
        `OFS_BOOST_SPEED: prdata <= {16'h0000, boost_speed_q};
        `OFS_BOOST_TIME: prdata <= {16'h0000, boost_time_q};
        `OFS_SCALE: prdata <= scale_q;
        `OFS_STATUS: prdata <= {25'h0, sup_active, wake_cond, sleep_cond, state_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************
  // Control tick and input sync
  // ********************************
  logic [11:0] div_q;
  logic tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 12'h000;
    end else if (div_q == 12'(TICK_CYC - 1)) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end
  assign tick = (div_q == 12'(TICK_CYC - 1));

  logic [NSW-1:0] sw_meta_q, sw_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_q <= '0;
      sw_sync_q <= '0;
    end else begin
      sw_meta_q <= switch_pins;
      sw_sync_q <= sw_meta_q;
    end
  end

  // ********************************
  // Sleep and wake conditions
  // ********************************
  pump_sleep_pkg::sleep_mode_t smode;
  pump_sleep_pkg::wake_mode_t wmode;
  pump_sleep_pkg::sensor_src_t snsrc;
  logic invert, sw_active, c_flow, c_speed, c_power, c_press;
  logic [2:0] sw_idx;
  logic [4:0] or_mask;
  logic [15:0] sensor_val;
  logic [16:0] err_lo, err_hi;

  assign smode = pump_sleep_pkg::sleep_mode_t'(ctrl_q[`CTRL_SMODE_LSB +: 3]);
  assign wmode = pump_sleep_pkg::wake_mode_t'(ctrl_q[`CTRL_WMODE_LSB +: 2]);
  assign snsrc = pump_sleep_pkg::sensor_src_t'(ctrl_q[`CTRL_SNSRC_LSB +: 2]);
  assign invert = ctrl_q[`CTRL_INV_BIT];
  assign sw_idx = ctrl_q[`CTRL_SWIDX_LSB +: 3];
  assign or_mask = ctrl_q[`CTRL_ORMASK_LSB +: 5];

  always_comb begin
    case (ctrl_q[`CTRL_SWSRC_LSB +: 2])
      2'h1: sw_active = (32'(sw_idx) < NSW) ? sw_sync_q[sw_idx] : 1'b0;
      2'h2: sw_active = (32'(sw_idx) < NSW) ? ctrl_word_bits[sw_idx] : 1'b0;
      default: sw_active = 1'b0;
    endcase
  end

  always_comb begin
    case (snsrc)
      pump_sleep_pkg::SRC_ANALOG:
        sensor_val = scale(proc_in.sens_analog, scale_q[15:0], scale_q[31:16]);
      pump_sleep_pkg::SRC_VIRTUAL:
        sensor_val = scale(proc_in.sens_virtual, scale_q[15:0], scale_q[31:16]);
      pump_sleep_pkg::SRC_PULSE:
        sensor_val = scale(proc_in.sens_pulse, scale_q[15:0], scale_q[31:16]);
      default: sensor_val = 16'h0000;
    endcase
  end

  // With no sensor assigned the flow condition can never hold.
  assign c_flow = (snsrc != pump_sleep_pkg::SRC_NONE) && sensor_val < sleep_level_q;
  assign c_speed = proc_in.out_freq < sleep_speed_q && ctx_in.aux_pumps_off;
  assign c_power = proc_in.out_power < sleep_power_q && ctx_in.aux_pumps_off;
  assign c_press = proc_in.pressure > press_level_q;

  always_comb begin
    case (smode)
      pump_sleep_pkg::SM_SWITCH: sleep_cond = sw_active;
      pump_sleep_pkg::SM_FLOW: sleep_cond = c_flow;
      pump_sleep_pkg::SM_SPEED: sleep_cond = c_speed;
      pump_sleep_pkg::SM_POWER: sleep_cond = c_power;
      pump_sleep_pkg::SM_PRESSURE: sleep_cond = c_press;
      pump_sleep_pkg::SM_ANY:
        sleep_cond = |(or_mask & {c_press, c_power, c_speed, c_flow, sw_active});
      default: sleep_cond = 1'b0;
    endcase
  end

  // The error band is computed one bit wider: the upper bound cannot wrap, and bit 16 flags a negative lower bound.
  assign err_lo = {1'b0, proc_in.reference} - {1'b0, wake_error_q};
  assign err_hi = {1'b0, proc_in.reference} + {1'b0, wake_error_q};

  always_comb begin
    case (wmode)
      pump_sleep_pkg::WM_FEEDBACK:
        wake_cond = invert ? proc_in.feedback > wake_level_q
                           : proc_in.feedback < wake_level_q;
      pump_sleep_pkg::WM_ERROR:
        wake_cond = invert ? {1'b0, proc_in.feedback} > err_hi
                           : !err_lo[16] && {1'b0, proc_in.feedback} < err_lo;
      pump_sleep_pkg::WM_PRESSURE: wake_cond = proc_in.pressure < wake_level_q;
      default: wake_cond = 1'b1;
    endcase
  end

  // ********************************
  // Supervisor state machine
  // ********************************
  logic pid_mode, pid_mode_q, run_q;
  logic [15:0] tmr_q;
  logic sleep_exp, wake_exp, boost_exp;

  assign pid_mode = ctx_in.reg_configured & ctx_in.chan1_selected & ctx_in.auto_mode;
  assign sup_active = ctx_in.fb_configured & ctrl_q[`CTRL_EN_BIT] & pid_mode;
  assign sleep_exp = tmr_q > sleep_delay_q;
  assign wake_exp = tmr_q > wake_delay_q;
  assign boost_exp = tmr_q >= boost_time_q - 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      pid_mode_q <= 1'b0;
    end else if (tick) begin
      run_q <= ctx_in.run_order;
      pid_mode_q <= pid_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pump_sleep_pkg::ST_RUNNING;
    end else if (tick) begin
      if (!sup_active || !ctx_in.run_order) begin
        state_q <= pump_sleep_pkg::ST_RUNNING;
      end else if (!run_q) begin
        // A fresh run order in auto: start only if there is demand.
        state_q <= wake_cond ? pump_sleep_pkg::ST_RUNNING
                             : pump_sleep_pkg::ST_SLEEPING;
      end else if (!pid_mode_q) begin
        state_q <= pump_sleep_pkg::ST_RUNNING;
      end else begin
        case (state_q)
          pump_sleep_pkg::ST_RUNNING:
            if (sleep_cond && !wake_cond && sleep_exp) begin
              state_q <= (boost_time_q == 16'h0000) ? pump_sleep_pkg::ST_SLEEPING
                                                   : pump_sleep_pkg::ST_BOOST;
            end
          pump_sleep_pkg::ST_BOOST:
            if (boost_exp) begin
              state_q <= pump_sleep_pkg::ST_SLEEPING;
            end
          pump_sleep_pkg::ST_SLEEPING:
            if (wake_cond) begin
              state_q <= pump_sleep_pkg::ST_WAKING;
            end
          pump_sleep_pkg::ST_WAKING:
            if (!wake_cond) begin
              state_q <= pump_sleep_pkg::ST_SLEEPING;
            end else if (wake_exp) begin
              state_q <= pump_sleep_pkg::ST_RUNNING;
            end
          default: state_q <= pump_sleep_pkg::ST_RUNNING;
        endcase
      end
    end
  end

  // One shared timer: it restarts when the delay timed in its state expires and whenever the
  // condition it is timing lapses.
  logic tmr_hold;
  always_comb begin
    case (state_q)
      pump_sleep_pkg::ST_RUNNING: tmr_hold = sleep_cond && !wake_cond && sup_active;
      pump_sleep_pkg::ST_BOOST: tmr_hold = 1'b1;
      pump_sleep_pkg::ST_WAKING: tmr_hold = wake_cond;
      default: tmr_hold = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= 16'h0000;
    end else if (tick) begin
      if (!tmr_hold || sleep_exp && state_q == pump_sleep_pkg::ST_RUNNING
          || boost_exp && state_q == pump_sleep_pkg::ST_BOOST
          || wake_exp && state_q == pump_sleep_pkg::ST_WAKING) begin
        tmr_q <= 16'h0000;
      end else if (tmr_q != 16'hffff) begin
        tmr_q <= tmr_q + 16'h0001;
      end
    end
  end

  // ********************************
  // Outputs
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_run <= 1'b0;
      motor_halt <= 1'b1;
      boost_active <= 1'b0;
      boost_speed_ref <= 16'h0000;
      sleeping <= 1'b0;
    end else begin
      // A fresh run order waits for the next tick to decide on demand, so a
      // cold start without demand never spins the motor up for a moment.
      regulator_run <= ctx_in.run_order && state_q == pump_sleep_pkg::ST_RUNNING
                       && (run_q || !sup_active);
      motor_halt <= !ctx_in.run_order || (state_q == pump_sleep_pkg::ST_SLEEPING)
                    || (state_q == pump_sleep_pkg::ST_WAKING)
                    || (sup_active && !run_q);
      boost_active <= state_q == pump_sleep_pkg::ST_BOOST;
      boost_speed_ref <= boost_speed_q;
      sleeping <= (state_q == pump_sleep_pkg::ST_SLEEPING)
                  || (state_q == pump_sleep_pkg::ST_WAKING);
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_boost_entry;
    tick && state_q == pump_sleep_pkg::ST_RUNNING && sup_active && ctx_in.run_order
      && run_q && pid_mode_q && sleep_cond && !wake_cond && sleep_exp;
  endsequence

  chk_sleep_no_cfg: assert property (
    smode == pump_sleep_pkg::SM_NONE |-> !sleep_cond) else $error("Sleep cond without mode.");
  chk_inactive_runs: assert property (
    tick && !sup_active |=> state_q == pump_sleep_pkg::ST_RUNNING)
    else $error("Supervisor acted while inactive.");
  chk_boost_entry: assert property (
    s_boost_entry and (boost_time_q != 16'h0000) |=> state_q == pump_sleep_pkg::ST_BOOST
    ##1 boost_active) else $error("Boost phase not entered.");
  chk_boost_skip: assert property (
    s_boost_entry and (boost_time_q == 16'h0000) |=> state_q == pump_sleep_pkg::ST_SLEEPING)
    else $error("Zero boost time not skipped.");
  chk_sleep_delay: assert property (
    $changed(state_q) && state_q == pump_sleep_pkg::ST_BOOST
    |-> $past(tmr_q) > $past(sleep_delay_q)) else $error("Boost entered without delay.");
  chk_wake_delay: assert property (
    tick && state_q == pump_sleep_pkg::ST_WAKING && wake_cond && !wake_exp && run_q
    && pid_mode_q && sup_active && ctx_in.run_order |=> state_q == pump_sleep_pkg::ST_WAKING)
    else $error("Woke before wake delay.");
  chk_timer_restart: assert property (
    tick && !tmr_hold |=> tmr_q == 16'h0000) else $error("Timer not restarted.");
  chk_cold_start: assert property (
    tick && sup_active && ctx_in.run_order && !run_q && !wake_cond
    |=> state_q == pump_sleep_pkg::ST_SLEEPING ##1 motor_halt && !boost_active)
    else $error("Cold start without demand did not sleep.");
  chk_halt_sleep: assert property (
    state_q == pump_sleep_pkg::ST_SLEEPING |=> motor_halt && !regulator_run)
    else $error("Motor not halted in sleep.");
endmodule

// >>> tb/pump_process_model.sv
`timescale 1ns/10ps
// ****
// Process sensors and motor speed path
// ****
module pump_process_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Process levels chosen by the bench
  input wire logic [15:0] fb,
  input wire logic [15:0] pr,
  input wire logic [15:0] pw,
  input wire logic [15:0] sn,
  input wire logic [15:0] fq,
  // Motor commands
  input wire logic motor_halt,
  input wire logic boost_active,
  input wire logic [15:0] boost_speed_ref,
  // Measurements
  output pump_sleep_pkg::process_in_t proc_in
);
  logic [15:0] freq_q;
  // The speed lags the command by a clock, as a real ramp never follows at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q <= 16'h0000;
    end else begin
      freq_q <= motor_halt ? 16'h0000 : (boost_active ? boost_speed_ref : fq);
    end
  end
  // The virtual sensor carries the inverse so that a wrong source choice shows.
  assign proc_in = {fb, 16'h0200, pr, freq_q, pw, sn, ~sn, sn};
endmodule

// >>> tb/test_pump_sleep_wakeup_control.sv
`timescale 1ns/10ps
`include "pump_sleep_cfg.svh"
module test_pump_sleep_wakeup_control;
  // ****
  // Signals, design and process model
  // ****
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, regulator_run, motor_halt, boost_active, sleeping;
  logic [15:0] boost_speed_ref;
  logic [15:0] fb = 16'h0150, pr = 16'h0100, pw = 16'h0200, fq = 16'h0100, sn = 16'h0200;
  logic [7:0] sw = 8'h00;
  pump_sleep_pkg::drive_ctx_t ctx = 6'h3f;
  pump_sleep_pkg::process_in_t proc_in;
  int mismatches = 0, n_tests = 0, cyc = 0, boost_cyc = 0, run_cyc = 0;
  pump_sleep_wakeup_control #(.TICK_CYC(4)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .proc_in(proc_in), .ctx_in(ctx),
    .switch_pins(sw), .ctrl_word_bits({sw[3:0], sw[7:4]}), .regulator_run(regulator_run),
    .motor_halt(motor_halt), .boost_active(boost_active), .boost_speed_ref(boost_speed_ref),
    .sleeping(sleeping));
  pump_process_model i_proc (.pclk(pclk), .presetn(presetn), .fb(fb), .pr(pr), .pw(pw),
    .sn(sn), .fq(fq), .motor_halt(motor_halt), .boost_active(boost_active),
    .boost_speed_ref(boost_speed_ref), .proc_in(proc_in));
  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    boost_cyc += (boost_active === 1'b1);
    run_cyc += (regulator_run === 1'b1);
    if (cyc == 8000) begin
      mismatches++;
      end_of_test();
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  function automatic logic hit(input int sel);
    case (sel)
      0: return boost_active === 1'b1;
      1: return sleeping === 1'b1 && motor_halt === 1'b1;
      default: return regulator_run === 1'b1;
    endcase
  endfunction
  // The state only moves on ticks, so every wait is bounded in clocks.
  task automatic wait_on(input int sel, input int lim);
    int i;
    i = 0;
    while (i < lim && !hit(sel)) begin
      @(posedge pclk);
      i++;
    end
    chk({31'h0, hit(sel)}, 32'h1);
  endtask
  // One knob is moved per row, the others sit at levels that meet no condition.
  task automatic cond(input logic [31:0] c, input logic [15:0] f, input int sel,
      input logic [15:0] v, input logic [7:0] b, input logic aux, input logic [1:0] e);
    logic [31:0] st;
    fb <= f;
    pr <= (sel == 0) ? v : 16'h0100;
    pw <= (sel == 1) ? v : 16'h0200;
    fq <= (sel == 2) ? v : 16'h0100;
    sn <= (sel == 3) ? v : 16'h0200;
    sw <= b;
    ctx.aux_pumps_off <= aux;
    wr(`OFS_CTRL, c);
    repeat (12) @(posedge pclk);
    rd(`OFS_STATUS, st);
    chk({30'h0, st[5:4]}, {30'h0, e});
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(`OFS_CTRL, q);
    chk(q, 32'h0);
    rd(`OFS_SCALE, q);
    chk(q, 32'hffff_0000);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, `OFS_STATUS, 32'hf, q, e);
    chk({31'h0, e}, 32'h1);
    wr(`OFS_BOOST_SPEED, 32'h0000_0123);
    rd(`OFS_BOOST_SPEED, q);
    chk(q, 32'h0000_0123);
  endtask
  task automatic t_table();
    wr(`OFS_SLEEP_LEVEL, 32'h80);
    wr(`OFS_SLEEP_SPEED, 32'h60);
    wr(`OFS_SLEEP_POWER, 32'h50);
    wr(`OFS_PRESS_LEVEL, 32'h300);
    wr(`OFS_WAKE_LEVEL, 32'h100);
    wr(`OFS_WAKE_ERROR, 32'h20);
    wr(`OFS_SLEEP_DELAY, 32'hffff);
    cond(32'h1005, 16'h0150, 3, 16'h0040, 8'h00, 1'b1, 2'h1);
    cond(32'h2005, 16'h00f0, 3, 16'hffbf, 8'h00, 1'b1, 2'h3);
    cond(32'h3005, 16'h0150, 3, 16'h0040, 8'h00, 1'b1, 2'h1);
    cond(32'h1005, 16'h0150, 3, 16'h0200, 8'h00, 1'b1, 2'h0);
    cond(32'h0713, 16'h0150, 0, 16'h0100, 8'h80, 1'b1, 2'h3);
    cond(32'h0713, 16'h01f0, 0, 16'h0100, 8'h08, 1'b1, 2'h0);
    cond(32'h04c3, 16'h00f0, 0, 16'h0100, 8'h04, 1'b1, 2'h1);
    cond(32'h0047, 16'h0150, 2, 16'h0050, 8'h00, 1'b1, 2'h3);
    cond(32'h0057, 16'h0150, 2, 16'h0050, 8'h00, 1'b0, 2'h0);
    cond(32'h0059, 16'h0230, 1, 16'h0040, 8'h00, 1'b1, 2'h3);
    cond(32'h002b, 16'h0150, 0, 16'h0310, 8'h00, 1'b1, 2'h1);
    cond(32'h002b, 16'h0150, 0, 16'h0080, 8'h00, 1'b1, 2'h2);
    cond(32'h2000d, 16'h0150, 1, 16'h0040, 8'h00, 1'b1, 2'h1);
    cond(32'h4400d, 16'h0150, 1, 16'h0040, 8'h00, 1'b1, 2'h0);
    cond(32'h0001, 16'h0150, 1, 16'h0040, 8'h00, 1'b1, 2'h0);
  endtask
  task automatic t_sleep();
    pw <= 16'h0200;
    wr(`OFS_SLEEP_DELAY, 32'h3);
    wr(`OFS_BOOST_TIME, 32'h2);
    wr(`OFS_WAKE_DELAY, 32'h2);
    wr(`OFS_CTRL, 32'h9);
    pw <= 16'h0040;
    repeat (8) @(posedge pclk);
    pw <= 16'h0200;
    repeat (8) @(posedge pclk);
    pw <= 16'h0040;
    boost_cyc = 0;
    repeat (12) @(posedge pclk);
    chk({31'h0, boost_active | sleeping}, 32'h0);
    wait_on(0, 40);
    chk({15'h0, motor_halt, boost_speed_ref}, 32'h0000_0123);
    wait_on(1, 40);
    chk(boost_cyc, 32'h8);
  endtask
  task automatic t_wake();
    fb <= 16'h00f0;
    repeat (8) @(posedge pclk);
    chk({30'h0, regulator_run, sleeping}, 32'h1);
    wait_on(2, 40);
    chk({30'h0, motor_halt, sleeping}, 32'h0);
  endtask
  task automatic t_noboost();
    wr(`OFS_BOOST_TIME, 32'h0);
    wr(`OFS_CTRL, 32'hb);
    fb <= 16'h0150;
    pr <= 16'h0310;
    boost_cyc = 0;
    wait_on(1, 60);
    chk(boost_cyc, 32'h0);
  endtask
  task automatic t_start();
    wr(`OFS_BOOST_TIME, 32'h2);
    ctx.run_order <= 1'b0;
    repeat (12) @(posedge pclk);
    chk({30'h0, motor_halt, sleeping}, 32'h2);
    boost_cyc = 0;
    run_cyc = 0;
    ctx.run_order <= 1'b1;
    wait_on(1, 12);
    chk({31'h0, regulator_run}, 32'h0);
    chk(boost_cyc + run_cyc, 32'h0);
    ctx.run_order <= 1'b0;
    fb <= 16'h00f0;
    repeat (12) @(posedge pclk);
    ctx.run_order <= 1'b1;
    wait_on(2, 10);
    chk({31'h0, sleeping}, 32'h0);
  endtask
  task automatic t_auto();
    ctx.auto_mode <= 1'b0;
    fb <= 16'h0150;
    repeat (12) @(posedge pclk);
    ctx.auto_mode <= 1'b1;
    repeat (12) @(posedge pclk);
    chk({29'h0, motor_halt, sleeping, boost_active}, 32'h0);
  endtask
  task automatic t_inactive();
    for (int k = 0; k < 3; k++) begin
      ctx[5 - k] <= 1'b0;
      repeat (40) @(posedge pclk);
      chk({30'h0, sleeping, regulator_run}, 32'h1);
      ctx[5 - k] <= 1'b1;
      @(posedge pclk);
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    chk({29'h0, motor_halt, regulator_run, sleeping}, 32'h4);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_table();
    t_sleep();
    t_wake();
    t_noboost();
    t_start();
    t_auto();
    t_inactive();
    end_of_test();
  end
endmodule
